// ===== tst_pkg.sv
// Constants and types for the thermometer and thermostat block.
// Assumes a 25 MHz system clock and a free-running link sampling clock.
// Notes on behaviour
// - Converts at 9 bits from reset, unprompted.
// - Conversions repeat back to back unless shutdown.
// - Temperature holds last result; reads never disturb.
// - Shutdown finishes current conversion, stores, then stops.
// - Resolution selectable 9 to 12 bits.
// - Conversion time doubles per extra bit.
// - Each result stored as two's complement.
// - Sign, integer, four fraction bits, four zeros.
// - Unused fraction bits read as zero.
// - Top bit of temperature is sign.
// - Serial bytes shift most significant bit first.
// - Pointer zero selects temperature, also after reset.
// - Setpoints reset to 80 and 75 degrees.
// - Each result compared with both setpoints.
// - Alarm needs programmed count of consecutive faults.
// - Comparator and interrupt modes differ in clearing.
// - Reset default comparator mode, one fault suffices.
// - Open-drain alarm asserts at or above high trip setpoint.
// - Standalone: data pin level selects hysteresis.
// - Slave address holds a 3-bit variant field.
// - Comparator alarm clears on first result below release.
// - Interrupt alarm clears on shutdown or any read.
// - Pointers 1, 2, 3: config, release, trip.
// - Alarm polarity configurable, active low after reset.
package tst_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CONV_TIME_9_MS = 150;
  localparam int CONV_CYCLES_9_DEF = CONV_TIME_9_MS * (CLK_HZ / 1000);
  localparam int STANDALONE_CYCLES = 1024;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_THYST = 2'h2;
  localparam logic [1:0] PTR_TOS = 2'h3;
  localparam int CFG_SD = 0;
  localparam int CFG_TM = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_F_LO = 3;
  localparam int CFG_R_LO = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h7f;
  localparam logic [15:0] TOS_RESET = 16'h5000;
  localparam logic [15:0] THYST_RESET = 16'h4b00;
  localparam logic [7:0] SETP_LO_MASK = 8'hf0;
  localparam logic [15:0] FRAC_MASK_12 = 16'hfff0;
  // Arbitrary value for the fixed upper address bits
  localparam logic [3:0] ADDR_UPPER = 4'h9;
  localparam logic [2:0] DEV_ADDR_DEF = 3'h0;
  localparam logic [2:0] FAULT_NEED [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  typedef enum logic [3:0] {
    LK_IDLE = 4'b0000,
    LK_ADDR = 4'b0001,
    LK_ACKA = 4'b0010,
    LK_RXP = 4'b0011,
    LK_ACKP = 4'b0100,
    LK_RXD = 4'b0101,
    LK_ACKD = 4'b0110,
    LK_RD = 4'b0111,
    LK_RACK = 4'b1000
  } tst_link_st_t;
  typedef enum logic {
    CV_RUN = 1'b0,
    CV_STBY = 1'b1
  } tst_conv_st_t;
endpackage

// ===== tst_thermostat.sv
// Thermometer readout, thermostat and 2-wire slave in one file.
// Assumes clk_link runs free and samples the serial pins; the
// converter result arrives on temp_sample in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none

module tst_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept a bit only once stages two and three agree
      q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
    end
  end
endmodule // tst_sync3

module tst_thermostat import tst_pkg::*; #(
  parameter logic [2:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter int CONV_CYCLES_9 = CONV_CYCLES_9_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic alarm_out,
  output logic alarm_oe_n,
  input wire logic [11:0] temp_sample,
  output logic conv_active
);
  if (CONV_CYCLES_9 < 1 || CONV_CYCLES_9 > 32'h1fffffff) begin : g_bad
    $error("CONV_CYCLES_9 out of range");
  end

  localparam logic [31:0] CC9 = 32'(CONV_CYCLES_9);
  localparam logic [10:0] SA_LAST = 11'(STANDALONE_CYCLES - 1);

  // System domain state
  logic [7:0] cfg_s_q;
  logic [15:0] tos_s_q;
  logic [15:0] thyst_s_q;
  logic ack_tgl_q;
  logic [15:0] temp_q;
  logic tmp_tgl_q;
  tst_conv_st_t conv_st_q;
  logic [31:0] cnt_q;
  logic alarm_q;
  logic [2:0] fcnt_q;
  logic expect_hi_q;
  logic alarm_oe_n_q;
  logic rd_seen_q;
  logic req_f;
  logic rd_f;

  // Link domain state
  logic scl_f;
  logic sda_f;
  logic ack_f;
  logic tmp_f;
  logic scl_p_q;
  logic sda_p_q;
  tst_link_st_t st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic mack_q;
  logic bidx_q;
  logic sda_oe_n_q;
  logic [1:0] ptr_q;
  logic [7:0] cfg_q;
  logic [15:0] tos_q;
  logic [15:0] thyst_q;
  logic [15:0] snap_q;
  logic [15:0] temp_l_q;
  logic [39:0] sent_q;
  logic req_tgl_q;
  logic rd_tgl_q;
  logic tmp_seen_q;
  logic [10:0] lo_cnt_q;
  logic stand_q;

  tst_sync3 #(.W(2)) u_sync_sys (
    .clk(clk_sys),
    .arst_n(arst_n),
    .d({req_tgl_q, rd_tgl_q}),
    .q({req_f, rd_f})
  );

  tst_sync3 #(.W(4)) u_sync_link (
    .clk(clk_link),
    .arst_n(arst_n),
    .d({scl_in, sda_in, ack_tgl_q, tmp_tgl_q}),
    .q({scl_f, sda_f, ack_f, tmp_f})
  );

  // Link side: bus events
  logic scl_rise;
  logic scl_fall;
  logic start_w;
  logic stop_w;
  logic ptr_en;
  logic wr_en;
  logic [7:0] rbyte;
  logic [15:0] tos_eff;
  logic [15:0] thyst_eff;
  logic [39:0] cur_vec;

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_w = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_w = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign ptr_en = (st_q == LK_RXP) && scl_fall && (bit_cnt_q == 4'h8);
  assign wr_en = (st_q == LK_RXD) && scl_fall && (bit_cnt_q == 4'h8);

  // Standalone: default setpoints, data pin picks the hysteresis
  assign tos_eff = stand_q ? TOS_RESET : tos_q;
  assign thyst_eff = stand_q ? (sda_f ? THYST_RESET : TOS_RESET)
                             : thyst_q;
  assign cur_vec = {cfg_q, tos_eff, thyst_eff};

  always_comb begin
    unique case (ptr_q)
      PTR_TEMP: rbyte = bidx_q ? snap_q[7:0] : snap_q[15:8];
      PTR_CFG: rbyte = cfg_q;
      PTR_THYST: rbyte = bidx_q ? thyst_eff[7:0] : thyst_eff[15:8];
      PTR_TOS: rbyte = bidx_q ? tos_eff[7:0] : tos_eff[15:8];
    endcase
  end

  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Slave protocol engine
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= LK_IDLE;
      bit_cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b1;
      bidx_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      snap_q <= 16'h0000;
      rd_tgl_q <= 1'b0;
    end else if (start_w) begin
      st_q <= LK_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_w) begin
      st_q <= LK_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (scl_rise && (st_q == LK_ADDR || st_q == LK_RXP ||
                       st_q == LK_RXD)) begin
        sr_q <= {sr_q[6:0], sda_f};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (scl_rise && st_q == LK_RACK) begin
        mack_q <= sda_f;
      end
      if (scl_fall) begin
        unique case (st_q)
          LK_IDLE: begin
          end
          LK_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              if (sr_q[7:1] == {ADDR_UPPER, DEV_ADDR}) begin
                st_q <= LK_ACKA;
                rw_q <= sr_q[0];
                sda_oe_n_q <= 1'b0;
                bidx_q <= 1'b0;
                // Snapshot keeps both bytes coherent
                snap_q <= temp_l_q;
                if (sr_q[0]) begin
                  rd_tgl_q <= ~rd_tgl_q;
                end
              end else begin
                st_q <= LK_IDLE;
              end
            end
          end
          LK_ACKA: begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              st_q <= LK_RD;
              tx_q <= rbyte;
              sda_oe_n_q <= rbyte[7];
              bidx_q <= ~bidx_q;
            end else begin
              st_q <= LK_RXP;
              sda_oe_n_q <= 1'b1;
            end
          end
          LK_RXP: begin
            if (bit_cnt_q == 4'h8) begin
              st_q <= LK_ACKP;
              sda_oe_n_q <= 1'b0;
            end
          end
          LK_RXD: begin
            if (bit_cnt_q == 4'h8) begin
              st_q <= LK_ACKD;
              sda_oe_n_q <= 1'b0;
              bidx_q <= ~bidx_q;
            end
          end
          LK_ACKP, LK_ACKD: begin
            st_q <= LK_RXD;
            bit_cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
          end
          LK_RD: begin
            if (bit_cnt_q == 4'h7) begin
              st_q <= LK_RACK;
              sda_oe_n_q <= 1'b1;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_n_q <= tx_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          LK_RACK: begin
            bit_cnt_q <= 4'h0;
            if (!mack_q) begin
              st_q <= LK_RD;
              tx_q <= rbyte;
              sda_oe_n_q <= rbyte[7];
              bidx_q <= ~bidx_q;
            end else begin
              st_q <= LK_IDLE;
            end
          end
          default: begin
            st_q <= LK_IDLE;
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Pointer and writable registers
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= PTR_TEMP;
      cfg_q <= CFG_RESET;
      tos_q <= TOS_RESET;
      thyst_q <= THYST_RESET;
    end else if (ptr_en) begin
      ptr_q <= sr_q[1:0];
    end else if (wr_en) begin
      unique case (ptr_q)
        PTR_TEMP: begin
        end
        PTR_CFG: cfg_q <= sr_q & CFG_WMASK;
        PTR_THYST: begin
          if (bidx_q) begin
            thyst_q[7:0] <= sr_q & SETP_LO_MASK;
          end else begin
            thyst_q[15:8] <= sr_q;
          end
        end
        PTR_TOS: begin
          if (bidx_q) begin
            tos_q[7:0] <= sr_q & SETP_LO_MASK;
          end else begin
            tos_q[15:8] <= sr_q;
          end
        end
      endcase
    end
  end

  // Standalone detect: serial clock held low for a long while
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt_q <= 11'h000;
      stand_q <= 1'b0;
    end else if (scl_f) begin
      lo_cnt_q <= 11'h000;
      stand_q <= 1'b0;
    end else if (lo_cnt_q == SA_LAST) begin
      stand_q <= 1'b1;
    end else begin
      lo_cnt_q <= lo_cnt_q + 11'h001;
    end
  end

  // Settings push: data held stable until the ack toggle returns
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      sent_q <= {CFG_RESET, TOS_RESET, THYST_RESET};
      req_tgl_q <= 1'b0;
    end else if (ack_f == req_tgl_q && cur_vec != sent_q) begin
      sent_q <= cur_vec;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // Result pull; results are far apart so data is long settled
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      temp_l_q <= 16'h0000;
      tmp_seen_q <= 1'b0;
    end else if (tmp_f != tmp_seen_q) begin
      temp_l_q <= temp_q;
      tmp_seen_q <= tmp_f;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

  // System side
  logic [1:0] res;
  logic sd;
  logic tm;
  logic [2:0] need;
  logic [31:0] conv_limit;
  logic done;
  logic [15:0] new_t;
  logic hi;
  logic lo;
  logic ev;
  logic [2:0] hit_n;
  logic rd_evt;
  logic clr_w;

  assign res = cfg_s_q[CFG_R_LO +: 2];
  assign sd = cfg_s_q[CFG_SD];
  assign tm = cfg_s_q[CFG_TM];
  assign need = FAULT_NEED[cfg_s_q[CFG_F_LO +: 2]];
  assign conv_limit = CC9 << res;
  assign done = (conv_st_q == CV_RUN) && (cnt_q >= conv_limit - 32'h1);
  assign new_t = {temp_sample, 4'h0} &
                 (FRAC_MASK_12 << (2'h3 - res));
  assign hi = $signed(new_t) >= $signed(tos_s_q);
  assign lo = $signed(new_t) < $signed(thyst_s_q);
  assign ev = tm ? (expect_hi_q ? hi : lo) : hi;
  assign hit_n = fcnt_q + 3'h1;
  assign rd_evt = rd_f != rd_seen_q;
  assign clr_w = tm && (rd_evt || (done && sd));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_s_q <= CFG_RESET;
      tos_s_q <= TOS_RESET;
      thyst_s_q <= THYST_RESET;
      ack_tgl_q <= 1'b0;
    end else if (req_f != ack_tgl_q) begin
      {cfg_s_q, tos_s_q, thyst_s_q} <= sent_q;
      ack_tgl_q <= req_f;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_seen_q <= 1'b0;
    end else begin
      rd_seen_q <= rd_f;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conv_st_q <= CV_RUN;
      cnt_q <= 32'h0;
      temp_q <= 16'h0000;
      tmp_tgl_q <= 1'b0;
    end else if (done) begin
      temp_q <= new_t;
      tmp_tgl_q <= ~tmp_tgl_q;
      cnt_q <= 32'h0;
      conv_st_q <= sd ? CV_STBY : CV_RUN;
    end else if (conv_st_q == CV_RUN) begin
      cnt_q <= cnt_q + 32'h1;
    end else if (!sd) begin
      conv_st_q <= CV_RUN;
    end
  end

  // Thermostat: clear first so a same-cycle set wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_q <= 1'b0;
      fcnt_q <= 3'h0;
      expect_hi_q <= 1'b1;
    end else begin
      if (clr_w) begin
        alarm_q <= 1'b0;
      end
      if (!tm) begin
        expect_hi_q <= 1'b1;
      end
      if (done) begin
        if (!tm && alarm_q) begin
          fcnt_q <= 3'h0;
          if (lo) begin
            alarm_q <= 1'b0;
          end
        end else if (ev) begin
          if (hit_n >= need) begin
            alarm_q <= 1'b1;
            fcnt_q <= 3'h0;
            if (tm) begin
              expect_hi_q <= ~expect_hi_q;
            end
          end else begin
            fcnt_q <= hit_n;
          end
        end else begin
          fcnt_q <= 3'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_oe_n_q <= 1'b1;
    end else begin
      // Released level is the pin's high level
      alarm_oe_n_q <= cfg_s_q[CFG_POL] ? alarm_q : ~alarm_q;
    end
  end

  assign alarm_out = 1'b0;
  assign alarm_oe_n = alarm_oe_n_q;
  assign conv_active = (conv_st_q == CV_RUN);

  chk_temp_only_done: assert property (@(posedge clk_sys)
    disable iff (!arst_n) $changed(temp_q) |-> $past(done))
    else $error("temperature changed without a conversion end");

  chk_low_nibble: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && res == 2'h0 |=> temp_q[6:0] == 7'h00)
    else $error("unused fraction bits not zero");

  chk_sd_standby: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && sd |=> conv_st_q == CV_STBY [*2])
    else $error("shutdown did not stop conversions");

  chk_keep_running: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && !sd |=> conv_st_q == CV_RUN && cnt_q == 0)
    else $error("conversion did not restart");

  chk_conv_length: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && $stable(res) && $past(cnt_q) != 0
    |-> $past(cnt_q) == conv_limit - 32'h2)
    else $error("conversion length wrong");

  chk_cmp_release: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && !tm && alarm_q && lo |=> !alarm_q)
    else $error("comparator alarm not released");

  chk_int_clear: assert property (@(posedge clk_sys)
    disable iff (!arst_n) tm && rd_evt && !done |=> !alarm_q)
    else $error("interrupt alarm not cleared by read");

  chk_pin_level: assert property (@(posedge clk_sys)
    disable iff (!arst_n) $rose(alarm_q) && !cfg_s_q[CFG_POL]
    && $stable(cfg_s_q) |=> !alarm_oe_n)
    else $error("active low alarm not driven");

  chk_one_fault: assert property (@(posedge clk_sys)
    disable iff (!arst_n) done && !tm && !alarm_q && hi && need == 3'h1
    |=> alarm_q)
    else $error("single fault did not raise alarm");

  chk_addr_ack: assert property (@(posedge clk_link)
    disable iff (!arst_n) st_q == LK_ACKA |-> !sda_oe_n_q)
    else $error("address not acknowledged");

  chk_ptr_write: assert property (@(posedge clk_link)
    disable iff (!arst_n) $changed(ptr_q) |-> $past(st_q) == LK_RXP)
    else $error("pointer changed outside pointer byte");
endmodule // tst_thermostat

`default_nettype wire

// ===== tst_host_model.sv
// Host controller model for the 2-wire bus, bit-banged on clk edges.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module tst_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // Quarter bit of 200 ns keeps SCL phases well above six link periods
  localparam int Q = 5;
  logic [6:0] dev = ADDR;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bit_x(input logic b, output logic s);
    tick(Q);
    sda_pull <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    s = sda_line;
    tick(Q);
    scl <= 1'b0;
  endtask

  task automatic start_c();
    tick(Q);
    sda_pull <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_pull <= 1'b1;
    tick(Q);
    scl <= 1'b0;
  endtask

  task automatic stop_c();
    tick(Q);
    sda_pull <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_pull <= 1'b0;
    tick(Q);
  endtask

  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask

  task automatic wbyte(input logic [7:0] d, inout logic ok);
    logic [7:0] r;
    logic a;
    byte_x(d, r);
    bit_x(1'b1, a);
    ok = ok & ~a;
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d,
                    input int n, output logic ok);
    ok = 1'b1;
    start_c();
    wbyte({dev, 1'b0}, ok);
    wbyte(p, ok);
    if (n > 0) wbyte(d[15:8], ok);
    if (n > 1) wbyte(d[7:0], ok);
    stop_c();
  endtask

  // Without setp the read uses whatever pointer is left standing
  task automatic rd(input logic [7:0] p, input logic setp, input int n,
                    output logic [15:0] d, output logic ok);
    logic a;
    ok = 1'b1;
    d = 16'h0000;
    if (setp) begin
      start_c();
      wbyte({dev, 1'b0}, ok);
      wbyte(p, ok);
    end
    start_c();
    wbyte({dev, 1'b1}, ok);
    byte_x(8'hff, d[15:8]);
    bit_x(n == 1, a);
    if (n > 1) begin
      byte_x(8'hff, d[7:0]);
      bit_x(1'b1, a);
    end
    stop_c();
  endtask

  // Standalone use: SCL grounded for n cycles, SDA picks hysteresis
  task automatic hold_low(input logic pull, input int n);
    tick(Q);
    scl <= 1'b0;
    tick(Q);
    sda_pull <= pull;
    tick(n);
    scl <= 1'b1;
    tick(Q);
    sda_pull <= 1'b0;
    tick(Q);
  endtask
endmodule // tst_host_model

`default_nettype wire

// ===== tst_thermostat_tb_top.sv
// Self-checking bench for the thermometer and thermostat block.
// Assumes the host model above; alarm pin is pulled up, so level = oe_n.
`timescale 1ns/1ps
`default_nettype none

module tst_thermostat_tb_top;
  import tst_pkg::*;
  localparam int CONV = 40;
  localparam logic [2:0] DEVA = 3'h5;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] temp_sample = 12'h191;
  logic scl;
  logic host_pull;
  logic sda_oe_n;
  logic alarm_oe_n;
  logic conv_active;
  wire sda_line;
  int bad_count = 0;
  int total_checks = 0;

  assign sda_line = ~host_pull & sda_oe_n;
  always #20 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;

  tst_thermostat #(.DEV_ADDR(DEVA), .CONV_CYCLES_9(CONV)) u_tst_thermostat (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_link(clk_link),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(),
    .sda_oe_n(sda_oe_n),
    .alarm_out(),
    .alarm_oe_n(alarm_oe_n),
    .temp_sample(temp_sample),
    .conv_active(conv_active)
  );

  tst_host_model #(.ADDR({ADDR_UPPER, DEVA})) u_tst_host_model (
    .clk(clk_sys),
    .sda_line(sda_line),
    .scl(scl),
    .sda_pull(host_pull)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] p, input logic s, input int n,
                     input logic [15:0] e, input string nm);
    logic [15:0] d;
    logic ok;
    u_tst_host_model.rd(p, s, n, d, ok);
    chk({nm, "_ack"}, 16'h0001, {15'h0, ok});
    chk(nm, e, d);
  endtask

  task automatic wrc(input logic [7:0] p, input logic [15:0] d, input int n);
    logic ok;
    u_tst_host_model.wr(p, d, n, ok);
    chk("write_ack", 16'h0001, {15'h0, ok});
  endtask

  // which: 0 alarm pin, 1 conversion activity
  task automatic wait_for(input int which, input logic lvl, input int n,
                          input string nm);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if ((which == 0 ? alarm_oe_n : conv_active) === lvl) break;
    end
    chk(nm, {15'h0, lvl}, {15'h0, which == 0 ? alarm_oe_n : conv_active});
    if (i >= n) conclude();
  endtask

  initial begin
    logic [15:0] d;
    logic ok;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    tk(80);
    rdc(8'h00, 1'b0, 2, 16'h1900, "temp_reset");
    rdc(8'h01, 1'b1, 1, 16'h0000, "cfg_reset");
    rdc(8'h02, 1'b1, 2, THYST_RESET, "rel_reset");
    rdc(8'h03, 1'b1, 2, TOS_RESET, "trip_reset");
    u_tst_host_model.dev = {ADDR_UPPER, 3'h0};
    u_tst_host_model.rd(8'h00, 1'b0, 2, d, ok);
    chk("wrong_addr_ack", 16'h0000, {15'h0, ok});
    u_tst_host_model.dev = {ADDR_UPPER, DEVA};
    wrc(8'h01, 16'h8000, 1);
    rdc(8'h01, 1'b0, 1, 16'h0000, "cfg_bit7");
    wrc(8'h00, 16'h1234, 2);
    rdc(8'h00, 1'b0, 2, 16'h1900, "temp_ro");
    wrc(8'h03, 16'h50ff, 2);
    rdc(8'h03, 1'b0, 2, 16'h50f0, "trip_lo");
    wrc(8'h03, TOS_RESET, 2);
    temp_sample <= 12'hf5e;
    for (int r = 0; r < 4; r++) begin
      wrc(8'h01, {1'b0, r[1:0], 5'h00, 8'h00}, 1);
      tk((CONV << r) * 2 + 40);
      rdc(8'h00, 1'b1, 2, 16'hf5e0 & (16'hfff0 << (3 - r)),
          "temp_res");
    end
    temp_sample <= 12'h0a0;
    wrc(8'h01, 16'h0100, 1);
    wait_for(1, 1'b0, CONV + 60, "conv_stop");
    temp_sample <= 12'h190;
    tk(200);
    chk("standby", 16'h0000, {15'h0, conv_active});
    rdc(8'h00, 1'b1, 2, 16'h0a00, "temp_sd");
    wrc(8'h01, 16'h0000, 1);
    wait_for(1, 1'b1, 60, "conv_run");
    tk(100);
    rdc(8'h00, 1'b1, 2, 16'h1900, "temp_run");
    // Comparator mode, single fault, then count of four
    temp_sample <= 12'h510;
    wait_for(0, 1'b0, 60, "cmp_one");
    temp_sample <= 12'h4a0;
    wait_for(0, 1'b1, 60, "cmp_clear");
    wrc(8'h01, 16'h1000, 1);
    tk(20);
    temp_sample <= 12'h510;
    tk(110);
    chk("cmp_count", 16'h0001, {15'h0, alarm_oe_n});
    wait_for(0, 1'b0, 80, "cmp_four");
    temp_sample <= 12'h4d0;
    tk(200);
    chk("cmp_hyst", 16'h0000, {15'h0, alarm_oe_n});
    temp_sample <= 12'h4a0;
    wait_for(0, 1'b1, 60, "cmp_release");
    wrc(8'h01, 16'h0400, 1);
    tk(20);
    chk("pol_high", 16'h0000, {15'h0, alarm_oe_n});
    // Interrupt mode: cleared by a read or by shutdown only
    wrc(8'h01, 16'h0200, 1);
    tk(20);
    temp_sample <= 12'h510;
    wait_for(0, 1'b0, 60, "int_hi");
    tk(100);
    chk("int_hold", 16'h0000, {15'h0, alarm_oe_n});
    rdc(8'h01, 1'b0, 1, 16'h0200, "cfg_int");
    wait_for(0, 1'b1, 20, "int_read_clr");
    tk(200);
    chk("int_once", 16'h0001, {15'h0, alarm_oe_n});
    temp_sample <= 12'h4a0;
    wait_for(0, 1'b0, 60, "int_lo");
    wrc(8'h01, 16'h0300, 1);
    wait_for(0, 1'b1, 60, "int_sd_clr");
    wrc(8'h01, 16'h0000, 1);
    wrc(8'h03, 16'h1e00, 2);
    temp_sample <= 12'h4d0;
    wait_for(0, 1'b0, 60, "trip_low_set");
    // Standalone lasts only while SCL stays low, so look during the hold
    fork
      u_tst_host_model.hold_low(1'b0, 1500);
      begin
        tk(1400);
        chk("alone_keep", 16'h0000, {15'h0, alarm_oe_n});
      end
    join
    fork
      u_tst_host_model.hold_low(1'b1, 1500);
      begin
        tk(1400);
        chk("alone_nohyst", 16'h0001, {15'h0, alarm_oe_n});
      end
    join
    rdc(8'h03, 1'b1, 2, 16'h1e00, "trip_kept");
    rdc(8'h02, 1'b1, 2, THYST_RESET, "rel_kept");
    conclude();
  end
endmodule // tst_thermostat_tb_top

`default_nettype wire
